// ### src/programmable_io_cell.sv
// Programmable I/O cell with its configuration registers on Avalon-MM.
`timescale 1ns/100ps

// Notes on behaviour
// - One configuration bit inverts the data sent to the pin.
// - Effective three-state control high turns the driver off.
// - Effective three-state control low turns the driver on.
// - Configuration picks driver on, off, or controlled from logic.
// - Another bit inverts the control so it acts as output enable.
// - Output data goes to the pin directly or through the register.
// - Output register captures on the rising edge of its clock.
// - Register clock is one of two edge lines, each invertible.
// - One bit selects fast or slew-limited output transitions.
// - One bit enables a weak pull-up on the pin.
// - Input path is direct, flip-flop or latch for synchronising.
// - Configuration written only while loading, read only in readback.
module programmable_io_cell (
	input  wire logic        mclk,        // System clock, 20 MHz.
	input  wire logic        resetn,      // Asynchronous reset, active low.
	input  wire logic        ce,          // Clock enable, freezes all state.
	input  wire logic [3:0]  address,     // Avalon byte address.
	input  wire logic        read,        // Avalon read request.
	input  wire logic        write,       // Avalon write request.
	input  wire logic [3:0]  byteenable,  // Avalon byte enables.
	input  wire logic [31:0] writedata,   // Avalon write data.
	output logic [31:0]      readdata,    // Avalon read data.
	output logic             waitrequest, // Avalon wait request.
	input  wire logic        cfg_load,    // Configuration loading in progress.
	input  wire logic        readback,    // Configuration readback in progress.
	input  wire logic        data_o,      // Output data from internal logic.
	input  wire logic        tri_t,       // Three-state control from logic.
	input  wire logic        edge_clk0,   // First edge clock line.
	input  wire logic        edge_clk1,   // Second edge clock line.
	input  wire logic        pin_in,      // Level seen on the pin.
	output logic             pin_out,     // Level driven onto the pin.
	output logic             pin_oe,      // Pin driver enable, high drives.
	output logic             slew_fast,   // Fast output transitions.
	output logic             pullup_en,   // Weak pull-up enabled.
	output logic             din          // Input data to internal logic.
);

	typedef struct packed {
		io_cell_pkg::bus_state_t bus;
		logic                    waitreq;
		logic [31:0]             rdata;
		logic [11:0]             cfg;
		logic                    clk_prev;
	} top_state_t;

	localparam top_state_t ST_RESET = '{
		bus:      io_cell_pkg::BUS_IDLE,
		waitreq:  1'b1,
		rdata:    io_cell_pkg::READ_ZERO,
		cfg:      io_cell_pkg::CFG_RESET,
		clk_prev: 1'b0
	};

	top_state_t  st;
	top_state_t  next_st;
	logic        clk_level;
	logic        clk_rise;
	logic        cfg_wr;
	logic [31:0] rd_mux;
	logic [31:0] status_word;
	logic        oreg_q;
	logic        out_inv;
	logic [1:0]  ts_mode;
	logic        ts_inv;
	logic        out_reg;
	logic [1:0]  in_mode;

	// Configuration fields as seen by the paths.
	assign out_inv = st.cfg[io_cell_pkg::OUT_INV_BIT];
	assign ts_mode = st.cfg[io_cell_pkg::TS_MODE_LO +: 2];
	assign ts_inv  = st.cfg[io_cell_pkg::TS_INV_BIT];
	assign out_reg = st.cfg[io_cell_pkg::OUT_REG_BIT];
	assign in_mode = st.cfg[io_cell_pkg::IN_MODE_LO +: 2];

	// Edge clock select and invert; the edge is found against the last level.
	always_comb begin
		if (st.cfg[io_cell_pkg::CLK_SEL_BIT]) begin
			clk_level = edge_clk1 ^ st.cfg[io_cell_pkg::EDGE1_INV_BIT];
		end else begin
			clk_level = edge_clk0 ^ st.cfg[io_cell_pkg::EDGE0_INV_BIT];
		end
		clk_rise = clk_level & ~st.clk_prev;
	end

	// Live cell state for software; readable at any time.
	always_comb begin
		status_word = io_cell_pkg::READ_ZERO;
		status_word[io_cell_pkg::ST_PIN_IN_BIT]  = pin_in;
		status_word[io_cell_pkg::ST_OE_BIT]      = pin_oe;
		status_word[io_cell_pkg::ST_PIN_OUT_BIT] = pin_out;
		status_word[io_cell_pkg::ST_OREG_BIT]    = oreg_q;
		status_word[io_cell_pkg::ST_DIN_BIT]     = din;
		status_word[io_cell_pkg::ST_LOAD_BIT]    = cfg_load;
	end

	// Configuration is hidden outside readback so user traffic cannot see it.
	always_comb begin
		rd_mux = io_cell_pkg::READ_ZERO;
		if (address == io_cell_pkg::CFG_ADDR && readback) begin
			rd_mux = {20'h0_0000, st.cfg};
		end else if (address == io_cell_pkg::STATUS_ADDR) begin
			rd_mux = status_word;
		end
	end

	// Bus handshake: one wait cycle, then a single answer cycle.
	always_comb begin
		next_st = st;
		cfg_wr = 1'b0;
		next_st.clk_prev = clk_level;
		case (st.bus)
			io_cell_pkg::BUS_IDLE: begin
				if (read || write) begin
					next_st.bus = io_cell_pkg::BUS_ANSWER;
					next_st.waitreq = 1'b0;
					next_st.rdata = read ? rd_mux : io_cell_pkg::READ_ZERO;
				end
			end
			io_cell_pkg::BUS_ANSWER: begin
				next_st.bus = io_cell_pkg::BUS_IDLE;
				next_st.waitreq = 1'b1;
				if (write && cfg_load && address == io_cell_pkg::CFG_ADDR) begin
					cfg_wr = 1'b1;
				end
			end
			default: begin
				next_st.bus = io_cell_pkg::BUS_IDLE;
				next_st.waitreq = 1'b1;
			end
		endcase
		// Byte lanes merge bit by bit; bits outside the field are ignored.
		for (int i = 0; i < io_cell_pkg::CFG_W; i++) begin
			if (cfg_wr && byteenable[i / 8]) begin
				next_st.cfg[i] = writedata[i];
			end
		end
	end

	// Single state register; a low clock enable holds everything.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st <= ST_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Bus and pad-control outputs come straight from state.
	assign readdata    = st.rdata;
	assign waitrequest = st.waitreq;
	assign slew_fast   = st.cfg[io_cell_pkg::SLEW_BIT];
	assign pullup_en   = st.cfg[io_cell_pkg::PULLUP_BIT];

	// Output side of the cell.
	io_output_path u_out (
		.mclk       (mclk),
		.resetn     (resetn),
		.ce         (ce),
		.data_o     (data_o),
		.tri_t      (tri_t),
		.invert     (out_inv),
		.ts_mode    (ts_mode),
		.ts_invert  (ts_inv),
		.registered (out_reg),
		.clk_rise   (clk_rise),
		.pin_out    (pin_out),
		.pin_oe     (pin_oe),
		.oreg_q     (oreg_q)
	);

	// Input side of the cell.
	io_input_path u_in (
		.mclk      (mclk),
		.resetn    (resetn),
		.ce        (ce),
		.pin_in    (pin_in),
		.in_mode   (in_mode),
		.clk_rise  (clk_rise),
		.clk_level (clk_level),
		.din       (din)
	);

	// Checks on the cell behaviour, all in the mclk domain.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// Configuration cannot change outside loading.
	a_cfg_write_lock: assert property (
		ce && !cfg_load |=> st.cfg == $past(st.cfg)
	) else $error("configuration changed outside loading");

	// Configuration reads as zero outside readback.
	a_cfg_read_hidden: assert property (
		ce && st.bus == io_cell_pkg::BUS_IDLE && read && !readback
		&& address == io_cell_pkg::CFG_ADDR
		|=> readdata == io_cell_pkg::READ_ZERO
	) else $error("configuration visible outside readback");

	// A request is answered on the next enabled cycle.
	a_bus_answer: assert property (
		ce && st.bus == io_cell_pkg::BUS_IDLE && (read || write)
		|=> !waitrequest ##1 waitrequest
	) else $error("bus answer not given in one cycle");

	// Forced-on driver.
	a_driver_on: assert property (
		ce && ts_mode == io_cell_pkg::TS_ON |=> pin_oe
	) else $error("driver not on when forced on");

	// Forced-off driver.
	a_driver_off: assert property (
		ce && ts_mode == io_cell_pkg::TS_OFF |=> !pin_oe
	) else $error("driver on when forced off");

	// Logic-controlled three-state, normal and inverted sense.
	a_ts_follow: assert property (
		ce && ts_mode == io_cell_pkg::TS_PIN
		|=> pin_oe == ($past(tri_t) == $past(ts_inv))
	) else $error("driver enable does not follow control");

	// Direct output path with inversion.
	a_direct_data: assert property (
		ce && !out_reg |=> pin_out == $past(data_o ^ out_inv)
	) else $error("direct output data wrong");

	// Registered path takes data on the selected rising edge.
	a_reg_capture: assert property (
		ce && out_reg && clk_rise
		|=> pin_out == $past(data_o ^ out_inv) ##1 oreg_q == $past(data_o, 2)
	) else $error("output register missed its edge");

	// Registered path holds between edges.
	a_reg_hold: assert property (
		ce && out_reg && !clk_rise |=> pin_out == $past(oreg_q ^ out_inv)
	) else $error("output register changed without edge");

	// Input keeps sampling; the edge leaving reset still held the flop.
	a_input_direct: assert property (
		ce && $past(resetn) && in_mode == io_cell_pkg::IN_DIRECT
		|=> din == $past(pin_in)
	) else $error("direct input not sampled");

	// Input flip-flop holds between edges.
	a_input_hold: assert property (
		ce && in_mode == io_cell_pkg::IN_FF && !clk_rise |=> $stable(din)
	) else $error("input flip-flop changed without edge");

	// A loading write sets the pad controls from its data.
	a_pad_controls: assert property (
		ce && cfg_wr && byteenable[0]
		|=> pullup_en == $past(writedata[io_cell_pkg::PULLUP_BIT])
		&& slew_fast == $past(writedata[io_cell_pkg::SLEW_BIT])
	) else $error("pad controls do not match configuration");

	// Frozen clock enable holds the pin.
	a_ce_freeze: assert property (
		!ce |=> $stable(pin_out) && $stable(pin_oe) && $stable(din)
	) else $error("state moved while clock enable low");

	// Inverted sense: the control acts as an output enable.
	a_ts_enable_sense: assert property (
		ce && ts_mode == io_cell_pkg::TS_PIN && ts_inv
		|=> pin_oe == $past(tri_t)
	) else $error("inverted control sense not honoured");

	// Plain sense, control high: the pin floats.
	a_ts_high_off: assert property (
		ce && ts_mode == io_cell_pkg::TS_PIN && !ts_inv && tri_t
		|=> !pin_oe
	) else $error("driver on while control high");

	// Plain sense, control low: the pin is driven.
	a_ts_low_on: assert property (
		ce && ts_mode == io_cell_pkg::TS_PIN && !ts_inv && !tri_t
		|=> pin_oe
	) else $error("driver off while control low");

	// Inversion bit flips the direct data.
	a_data_invert: assert property (
		ce && !out_reg && out_inv |=> pin_out != $past(data_o)
	) else $error("output data not inverted");

	// A rise on line 0, after its invert, loads the output register.
	a_edge_line0: assert property (
		ce && !st.cfg[io_cell_pkg::CLK_SEL_BIT] && !st.clk_prev
		&& (edge_clk0 ^ st.cfg[io_cell_pkg::EDGE0_INV_BIT])
		|=> oreg_q == $past(data_o)
	) else $error("edge line 0 did not clock the register");

	// The same for line 1 when it is the selected clock.
	a_edge_line1: assert property (
		ce && st.cfg[io_cell_pkg::CLK_SEL_BIT] && !st.clk_prev
		&& (edge_clk1 ^ st.cfg[io_cell_pkg::EDGE1_INV_BIT])
		|=> oreg_q == $past(data_o)
	) else $error("edge line 1 did not clock the register");

	// Input latch is transparent while the selected level is high.
	a_latch_open: assert property (
		ce && in_mode == io_cell_pkg::IN_LATCH && clk_level
		|=> din == $past(pin_in)
	) else $error("input latch not transparent");

	// Input latch holds while the selected level is low.
	a_latch_shut: assert property (
		ce && in_mode == io_cell_pkg::IN_LATCH && !clk_level |=> $stable(din)
	) else $error("input latch changed while closed");

	// Input flip-flop takes the pin on the selected rise.
	a_input_take: assert property (
		ce && in_mode == io_cell_pkg::IN_FF && clk_rise
		|=> din == $past(pin_in)
	) else $error("input flip-flop missed its edge");

	// Status reads return the live pin state of the taking cycle.
	a_status_read: assert property (
		ce && st.bus == io_cell_pkg::BUS_IDLE && read
		&& address == io_cell_pkg::STATUS_ADDR
		|=> readdata[io_cell_pkg::ST_PIN_IN_BIT] == $past(pin_in)
		&& readdata[io_cell_pkg::ST_OE_BIT] == $past(pin_oe)
		&& readdata[31:6] == 26'h000_0000
	) else $error("status word wrong");

	// Readback shows the whole configuration word.
	a_cfg_readback: assert property (
		ce && st.bus == io_cell_pkg::BUS_IDLE && read && readback
		&& address == io_cell_pkg::CFG_ADDR
		|=> readdata == {20'h0_0000, $past(st.cfg)}
	) else $error("readback word wrong");

	// A full-width write while loading stores every field.
	a_cfg_store: assert property (
		ce && cfg_wr && byteenable == 4'hf
		|=> st.cfg == $past(writedata[11:0])
	) else $error("configuration write not stored");

	// A disabled upper lane leaves the input-mode and edge-invert fields untouched.
	a_lane_keep: assert property (
		ce && cfg_wr && !byteenable[1]
		|=> st.cfg[11:8] == $past(st.cfg[11:8])
	) else $error("masked byte lane was written");

	// Without a request the slave keeps waitrequest high.
	a_wait_idle: assert property (
		ce && st.bus == io_cell_pkg::BUS_IDLE && !read && !write
		|=> waitrequest
	) else $error("waitrequest dropped without a request");

	c_cfg_write: cover property (cfg_wr && ce);
	c_reg_edge: cover property (ce && out_reg && clk_rise);
	c_open_drain: cover property (ce && ts_mode == io_cell_pkg::TS_PIN
		&& !ts_inv && data_o == tri_t && !data_o);
	c_latch_mode: cover property (ce && in_mode == io_cell_pkg::IN_LATCH
		&& clk_level);
	c_ts_sense: cover property (ce && ts_mode == io_cell_pkg::TS_PIN && ts_inv);

endmodule : programmable_io_cell

// ### src/io_cell_pkg.sv
// Constants shared by the programmable I/O cell and its path modules.
package io_cell_pkg;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [3:0] CFG_ADDR    = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;

	// Field positions inside the configuration register.
	localparam int unsigned CFG_W        = 12;
	localparam int unsigned OUT_INV_BIT  = 0;
	localparam int unsigned TS_MODE_LO   = 1;
	localparam int unsigned TS_INV_BIT   = 3;
	localparam int unsigned OUT_REG_BIT  = 4;
	localparam int unsigned CLK_SEL_BIT  = 5;
	localparam int unsigned SLEW_BIT     = 6;
	localparam int unsigned PULLUP_BIT   = 7;
	localparam int unsigned IN_MODE_LO   = 8;
	localparam int unsigned EDGE0_INV_BIT = 10;
	localparam int unsigned EDGE1_INV_BIT = 11;

	// Driver starts switched off so nothing fights the board at power-up.
	localparam logic [11:0] CFG_RESET = 12'h004;

	// Three-state control modes.
	localparam logic [1:0] TS_PIN = 2'h0;
	localparam logic [1:0] TS_ON  = 2'h1;
	localparam logic [1:0] TS_OFF = 2'h2;

	// Input path modes.
	localparam logic [1:0] IN_DIRECT = 2'h0;
	localparam logic [1:0] IN_FF     = 2'h1;
	localparam logic [1:0] IN_LATCH  = 2'h2;

	// Field positions inside the status register.
	localparam int unsigned ST_PIN_IN_BIT  = 0;
	localparam int unsigned ST_OE_BIT      = 1;
	localparam int unsigned ST_PIN_OUT_BIT = 2;
	localparam int unsigned ST_OREG_BIT    = 3;
	localparam int unsigned ST_DIN_BIT     = 4;
	localparam int unsigned ST_LOAD_BIT    = 5;

	// Answer for reads that reach no readable register.
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Bus handshake states.
	typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

endpackage : io_cell_pkg

// ### src/io_output_path.sv
// Output data and three-state path of the I/O cell.
`timescale 1ns/100ps
module io_output_path (
	input  wire logic       mclk,       // System clock.
	input  wire logic       resetn,     // Asynchronous reset, active low.
	input  wire logic       ce,         // Clock enable.
	input  wire logic       data_o,     // Data from internal logic.
	input  wire logic       tri_t,      // Three-state control from logic.
	input  wire logic       invert,     // Invert outgoing data.
	input  wire logic [1:0] ts_mode,    // Driver on, off or pin-controlled.
	input  wire logic       ts_invert,  // Control acts as output enable.
	input  wire logic       registered, // Use the output register.
	input  wire logic       clk_rise,   // Rising edge of selected edge clock.
	output logic            pin_out,    // Level driven toward the pin.
	output logic            pin_oe,     // Driver enabled.
	output logic            oreg_q      // Output register content.
);

	typedef struct packed {
		logic oreg;
		logic pin_o;
		logic oe;
	} out_state_t;

	out_state_t st;
	out_state_t next_st;
	logic       ts_eff;

	// Register capture, data select, inversion and driver enable.
	always_comb begin
		next_st = st;
		next_st.oreg = clk_rise ? data_o : st.oreg;
		next_st.pin_o = registered ? next_st.oreg : data_o;
		next_st.pin_o = next_st.pin_o ^ invert;
		case (ts_mode)
			io_cell_pkg::TS_PIN: ts_eff = tri_t ^ ts_invert;
			io_cell_pkg::TS_ON:  ts_eff = 1'b0;
			default:             ts_eff = 1'b1;
		endcase
		next_st.oe = ~ts_eff;
	end

	// State register; driver off while reset is held.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign pin_out = st.pin_o;
	assign pin_oe  = st.oe;
	assign oreg_q  = st.oreg;

endmodule : io_output_path

// ### src/io_input_path.sv
// Input path of the I/O cell: direct, flip-flop or latch.
`timescale 1ns/100ps
module io_input_path (
	input  wire logic       mclk,      // System clock.
	input  wire logic       resetn,    // Asynchronous reset, active low.
	input  wire logic       ce,        // Clock enable.
	input  wire logic       pin_in,    // Level seen on the pin.
	input  wire logic [1:0] in_mode,   // Direct, flip-flop or latch.
	input  wire logic       clk_rise,  // Rising edge of selected edge clock.
	input  wire logic       clk_level, // Level of selected edge clock.
	output logic            din        // Data toward internal logic.
);

	typedef struct packed {
		logic q;
	} in_state_t;

	in_state_t st;
	in_state_t next_st;

	// The pin is sampled whatever the driver does, so the cell is bidirectional.
	always_comb begin
		next_st = st;
		case (in_mode)
			io_cell_pkg::IN_FF:    next_st.q = clk_rise ? pin_in : st.q;
			io_cell_pkg::IN_LATCH: next_st.q = clk_level ? pin_in : st.q;
			default:               next_st.q = pin_in;
		endcase
	end

	// State register.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign din = st.q;

endmodule : io_input_path

// ### verification/board_pin.sv
// Board-side model of the net that hangs on the cell's package pin.
`timescale 1ns/100ps
module board_pin (
	input  wire logic mclk,      // System clock.
	input  wire logic pin_out,   // Level driven by the cell.
	input  wire logic pin_oe,    // High while the cell drives.
	input  wire logic pullup_en, // Weak pull-up of the cell.
	input  wire logic ext_en,    // Board driver enabled.
	input  wire logic ext_val,   // Board driver level.
	output logic      pin_in     // Resolved net level.
);
	logic last = 1'h0;

	// Resolve the net; a floating net shows the inverse of its last level,
	// so that a stale value can never pass for a real one.
	always_comb begin
		if (pin_oe && ext_en)
			pin_in = 1'hx;
		else if (pin_oe)
			pin_in = pin_out;
		else if (ext_en)
			pin_in = ext_val;
		else if (pullup_en)
			pin_in = 1'h1;
		else
			pin_in = !last;
	end

	// Remember the level of the previous cycle for the floating case.
	always_ff @(posedge mclk)
		last <= pin_in;
endmodule : board_pin

// ### verification/tb.sv
// Self-checking testbench for the programmable I/O cell.
`timescale 1ns/100ps
module tb;
	logic        mclk, resetn, ce, read, write, cfg_load, readback;
	logic        data_o, tri_t, waitrequest, pin_in, pin_out, pin_oe;
	logic        slew_fast, pullup_en, din, ext_en, ext_val;
	logic        d, t, ee, ev, oe, lat;
	logic [1:0]  ec;
	logic [3:0]  address, byteenable;
	logic [11:0] c;
	logic [31:0] writedata, readdata, q;
	int          checked, num_errors;

	programmable_io_cell i_dut (.mclk(mclk), .resetn(resetn), .ce(ce),
		.address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.cfg_load(cfg_load), .readback(readback), .data_o(data_o),
		.tri_t(tri_t), .edge_clk0(ec[0]), .edge_clk1(ec[1]),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.slew_fast(slew_fast), .pullup_en(pullup_en), .din(din));

	board_pin i_board (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val),
		.pin_in(pin_in));

	// Free-running system clock of 50 ns.
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// Compares with case equality so that an unknown never matches.
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	// One Avalon transfer; the request is held until waitrequest is low.
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] dat);
		int i;
		address   <= a;
		writedata <= dat;
		write     <= wr;
		read      <= !wr;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (waitrequest !== 1'h0 && i < 20);
		q = readdata;
		write <= 1'h0;
		read  <= 1'h0;
		if (waitrequest !== 1'h0) begin
			num_errors++;
			stop_test();
		end
		@(posedge mclk);
	endtask : bus

	// Loads a configuration; the board lets go first to avoid contention.
	task automatic cfg_wr(input logic [11:0] v);
		ext_en   <= 1'h0;
		cfg_load <= 1'h1;
		bus(1'h1, io_cell_pkg::CFG_ADDR, {20'h0_0000, v});
		cfg_load <= 1'h0;
	endtask : cfg_wr

	// Expected driver enable for a configuration and a control level.
	function automatic logic exp_oe(input logic [11:0] v, input logic tt);
		if (v[2:1] == io_cell_pkg::TS_ON)
			return 1'h1;
		if (v[2:1] != io_cell_pkg::TS_PIN)
			return 1'h0;
		return v[3] ? tt : !tt;
	endfunction : exp_oe

	// Main sequence: reset, register access, then the pin paths.
	initial begin
		resetn = 1'h0;
		ce = 1'h1;
		{read, write, cfg_load, readback, data_o, tri_t} = 6'h00;
		{ext_en, ext_val} = 2'h0;
		ec = 2'h0;
		address = 4'h0;
		byteenable = 4'hf;
		writedata = 32'h0000_0000;
		checked = 0;
		num_errors = 0;
		void'($urandom(89505));
		cyc(4);
		check("oe_reset", pin_oe, 1'h0);
		resetn <= 1'h1;
		cyc(1);
		readback <= 1'h1;
		bus(1'h0, io_cell_pkg::CFG_ADDR, 32'h0000_0000);
		check("cfg_reset", q, {20'h0_0000, io_cell_pkg::CFG_RESET});
		bus(1'h1, io_cell_pkg::CFG_ADDR, 32'h0000_00ff);
		bus(1'h0, io_cell_pkg::CFG_ADDR, 32'h0000_0000);
		check("cfg_kept", q, {20'h0_0000, io_cell_pkg::CFG_RESET});
		readback <= 1'h0;
		bus(1'h0, io_cell_pkg::CFG_ADDR, 32'h0000_0000);
		check("cfg_hidden", q, 32'h0000_0000);
		bus(1'h0, 4'h8, 32'h0000_0000);
		check("unmapped", q, 32'h0000_0000);
		bus(1'h0, io_cell_pkg::STATUS_ADDR, 32'h0000_0000);
		check("status", q & 32'h0000_0022, 32'h0000_0000);
		// Random direct configurations; the board drives only an idle pin.
		repeat (40) begin
			c = 12'($urandom) & 12'hcef;
			{d, t, ee, ev} = 4'($urandom);
			oe = exp_oe(c, t);
			cfg_wr(c);
			data_o  <= d;
			tri_t   <= t;
			ext_val <= ev;
			// The board waits a cycle so it never fights a stale enable.
			cyc(1);
			ext_en  <= ee && !oe;
			cyc(3);
			check("pin_out", pin_out, d ^ c[0]);
			check("pin_oe", pin_oe, oe);
			check("slew", slew_fast, c[6]);
			check("pullup", pullup_en, c[7]);
			if (oe || ee || c[7])
				check("din", din, oe ? d ^ c[0] : (ee ? ev : 1'h1));
		end
		readback <= 1'h1;
		bus(1'h0, io_cell_pkg::CFG_ADDR, 32'h0000_0000);
		check("cfg_read", q, {20'h0_0000, c});
		// Only the low lane is enabled, so the input-mode and edge-invert fields must survive.
		byteenable <= 4'h1;
		cfg_wr(12'h0ff);
		byteenable <= 4'hf;
		bus(1'h0, io_cell_pkg::CFG_ADDR, 32'h0000_0000);
		check("cfg_lane", q, {20'h0_0000, c[11:8], 8'hff});
		readback <= 1'h0;
		// One net on data and control gives an open-drain pin.
		cfg_wr(12'h080);
		for (int x = 0; x < 2; x++) begin
			data_o <= x[0];
			tri_t  <= x[0];
			cyc(3);
			check("od_oe", pin_oe, !x[0]);
			check("od_pin", din, x[0]);
		end
		// Registered output on each edge line, plain and inverted.
		for (int k = 0; k < 4; k++) begin
			c = 12'h012 | (12'(k[0]) << 5) | (12'(k[1]) << (10 + k[0]));
			ec <= {2{k[1]}};
			cfg_wr(c);
			d = 1'($urandom);
			data_o <= d;
			cyc(3);
			ec[k[0]] <= !k[1];
			cyc(2);
			data_o <= !d;
			ec[!k[0]] <= !ec[!k[0]];
			cyc(3);
			check("oreg_hold", pin_out, d);
			ec[k[0]] <= k[1];
			cyc(3);
			check("oreg_fall", pin_out, d);
			ec[k[0]] <= !k[1];
			cyc(3);
			check("oreg_rise", pin_out, !d);
		end
		// Input flip-flop and latch, with the driver on the same pin.
		for (int m = 1; m < 3; m++) begin
			lat = (m == 2);
			ec <= 2'h0;
			cfg_wr(12'h002 | (12'(m) << 8));
			data_o <= 1'h1;
			cyc(3);
			ec[0] <= 1'h1;
			cyc(3);
			check("in_capture", din, 1'h1);
			data_o <= 1'h0;
			cyc(3);
			check("in_high", din, !lat);
			ec[0] <= 1'h0;
			cyc(2);
			data_o <= lat;
			cyc(3);
			check("in_low", din, !lat);
		end
		// A low clock enable freezes the pin path.
		ce <= 1'h0;
		data_o <= 1'h0;
		cyc(3);
		check("frozen", pin_out, 1'h1);
		ce <= 1'h1;
		cyc(3);
		check("resumed", pin_out, 1'h0);
		stop_test();
	end
endmodule : tb
